// ===== rtl/swd_dispatch.sv
// Contract
// (RULE_01) pin event with enables vectors 0x03
// (RULE_02) sleep, no ADC enables: stop converter
// (RULE_03) sleep, ADC irq only: flag, stop, no wake
// (RULE_04) ADC wake enable keeps clock, wakes
// (RULE_05) ADC irq, globally off: flag only
// (RULE_06) ADC irq, globally on: vector 0x0C
// (RULE_07) PWM match with enables: flag, vector
// (RULE_08) PWM match, globally off: flag only
// (RULE_09) comparator, no enables: no wake
// (RULE_10) comparator irq only: flag, no wake
// (RULE_11) comparator wake only: wake, continue
// (RULE_12) comparator both, globally off: wake, flag
// (RULE_13) comparator irq, globally on: vector
// (RULE_14) comparator irq off: no interrupt
// (RULE_15) low voltage, no enables: nothing
// (RULE_16) low voltage irq only: flag bit 6
// (RULE_17) low voltage wake only: wake, continue
// (RULE_18) low voltage, globally off: flag, continue
// (RULE_19) low voltage, globally on: vector 0x1B
// (RULE_20) watchdog time-out resets to 0x00
// (RULE_21) timer overflow vectors 0x09
// (RULE_22) after wake: interrupt if enabled
// (RULE_23) flags stay until software clears
// (RULE_24) one at a time, fixed priority
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module swd_dispatch
   import swd_pkg::*;
(
   input  wire logic                clock_i,
   input  wire logic                rst_i,
   // avalon-mm slave
   input  wire logic [4:0]          avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [31:0]         avs_writedata_i,
   input  wire logic [3:0]          avs_byteenable_i,
   output logic      [31:0]         avs_readdata_o,
   output logic                     avs_waitrequest_o,
   // peripheral events
   input  wire swd_pkg::swd_evt_t   event_i,
   input  wire logic                ext_pin_i,
   input  wire logic                watchdog_timeout_i,
   // core sequencer
   input  wire logic                sleep_i,
   input  wire logic                global_irq_on_instr_i,
   input  wire logic                global_irq_off_instr_i,
   input  wire logic                vector_ack_i,
   output swd_pkg::swd_vec_t        vector_req_o,
   output logic                     wake_o,
   output logic                     reset_req_o,
   output logic [7:0]               reset_vector_o,
   output logic                     osc_keep_running_o,
   output logic                     adc_stop_o,
   output logic                     conversion_running_o
);
   import swd_pkg::*;

   // register file
   logic [7:0]       irq_flag_reg;            // sticky flags
   logic [7:0]       irq_flag_next;
   logic [7:0]       irq_enable_reg;          // per-source enables
   logic [7:0]       wake_control_reg;        // wake enables
   logic [7:0]       adc_control_reg;         // conversion running
   logic [7:0]       adc_control_next;
   logic [7:0]       low_voltage_control_reg; // lvd wake and irq enable
   logic [7:0]       watchdog_reg;            // watchdog enable
   logic             gie_reg;                 // global interrupt enable
   logic [7:0]       service_reg;             // vectors still owed
   logic [7:0]       service_next;
   logic             done_reg;                // bus answer strobe
   logic [31:0]      rdata_reg;               // read data
   logic [31:0]      rdata_next;
   logic             wake_reg;                // wake pulse
   logic             rstreq_reg;              // reset request pulse
   logic             pin_s1_reg;              // pin sync stage 1
   logic             pin_s2_reg;              // pin sync stage 2
   logic             pin_s3_reg;              // edge history
   swd_state_t       state_reg;
   swd_state_t       state_next;
   logic [2:0]       sel_reg;                 // source being vectored
   logic [2:0]       sel_next;

   // decode
   wire              bus_req   = avs_read_i | avs_write_i;
   wire              bus_take  = bus_req & ~done_reg;
   wire              wr_take   = avs_write_i & done_reg & avs_byteenable_i[0]; // lands in answer cycle
   wire [7:0]        wdat      = avs_writedata_i[7:0];
   wire              wr_flag   = wr_take & (avs_address_i == OFS_FLAG);
   wire              wr_ien    = wr_take & (avs_address_i == OFS_IEN);
   wire              wr_wake   = wr_take & (avs_address_i == OFS_WAKE);
   wire              wr_adc    = wr_take & (avs_address_i == OFS_ADC);
   wire              wr_lvd    = wr_take & (avs_address_i == OFS_LVD);
   wire              wr_wdog   = wr_take & (avs_address_i == OFS_WDOG);

   // effective enables per source
   wire              lvd_ien   = low_voltage_control_reg[BIT_LVD_IEN];
   wire              lvd_wake  = low_voltage_control_reg[BIT_LVD_WAKE];
   wire              adc_wake  = wake_control_reg[BIT_WAKE_ADC];
   wire              cmp_wake  = wake_control_reg[BIT_WAKE_CMP];
   wire              adc_run   = adc_control_reg[BIT_ADC_RUN];
   wire              wdog_en   = watchdog_reg[BIT_WDOG_EN];
   wire              pin_fall  = pin_s3_reg & ~pin_s2_reg;
   wire [7:0]        ev_raw;
   wire [7:0]        ien_eff;
   wire [7:0]        wake_en;
   wire [7:0]        ev_flag;
   wire [7:0]        ev_serve;
   wire [7:0]        ev_wake;

   // sleep with no adc wake stops a running conversion
   wire              adc_abort = sleep_i & ~adc_wake & adc_run; // [RULE_02]
   wire              adc_abort_flag = adc_abort & irq_enable_reg[SRC_ADC]; // [RULE_03]
   wire              adc_halt  = sleep_i & ~adc_wake; // converter held off in sleep without adc wake

   // pin event replaces the ext bit of the event bundle
   assign ev_raw = {event_i[7:3], pin_fall, event_i[1:0]};

   // per-source enables, wake enables and outcomes
   genvar g;
   generate
      for (g = 0; g < SRC_N; g++)
      begin : g_src
         if (g == SRC_LVD)
         begin : g_lvd
            assign ien_eff[g] = lvd_ien;
         end
         else
         begin : g_std
            assign ien_eff[g] = irq_enable_reg[g];
         end
         if (g == SRC_ADC)
         begin : g_wa
            assign wake_en[g] = adc_wake;
         end
         else if (g == SRC_CMP)
         begin : g_wc
            assign wake_en[g] = cmp_wake;
         end
         else if (g == SRC_LVD)
         begin : g_wl
            assign wake_en[g] = lvd_wake;
         end
         else
         begin : g_wn
            assign wake_en[g] = 1'b0;
         end
         // flag only with the source irq enable, independent of gie
         assign ev_flag[g]  = ev_raw[g] & ien_eff[g]; // [RULE_05] [RULE_08] [RULE_10] [RULE_16]
         // wake only with the source wake enable while asleep
         assign ev_wake[g]  = ev_raw[g] & wake_en[g] & sleep_i; // [RULE_09] [RULE_11] [RULE_17]
         // vector owed only with gie, and awake or woken by it
         assign ev_serve[g] = ev_flag[g] & gie_reg
                              & (~sleep_i | wake_en[g]); // [RULE_13] [RULE_14] [RULE_22]
      end
   endgenerate

   // fixed priority: lowest source index first
   always_comb
   begin
      sel_next = sel_reg;
      for (int i = SRC_N - 1; i >= 0; i--)
      begin
         if (service_reg[i])
         begin
            sel_next = i[2:0]; // [RULE_24]
         end
      end
   end

   // dispatch sequence: offer one vector, wait for the core
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (|service_reg & gie_reg)
            begin
               state_next = ST_VEC;
            end
         end
         ST_VEC:
         begin
            if (vector_ack_i)
            begin
               state_next = ST_REL;
            end
         end
         ST_REL:
         begin
            state_next = ST_IDLE; // with ST_IDLE, a two-cycle gap between vectors
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   wire              ack_take = (state_reg == ST_VEC) & vector_ack_i;

   // owed vectors: set wins over the ack that retires one
   always_comb
   begin
      service_next = service_reg;
      if (ack_take)
      begin
         service_next[sel_reg] = 1'b0;
      end
      service_next = service_next & ien_eff; // disabled source owes nothing
      service_next = service_next | ev_serve; // [RULE_01] [RULE_06] [RULE_07] [RULE_19] [RULE_21]
   end

   // flags: software writes 1 to clear, a new event wins
   always_comb
   begin
      irq_flag_next = irq_flag_reg;
      if (wr_flag)
      begin
         irq_flag_next = irq_flag_reg & ~wdat;
      end
      irq_flag_next = irq_flag_next | ev_flag; // [RULE_23] [RULE_18] [RULE_12]
      if (adc_abort_flag)
      begin
         irq_flag_next[SRC_ADC] = 1'b1;
      end
   end

   // conversion running: set by software, cleared by done or abort
   always_comb
   begin
      adc_control_next = adc_control_reg;
      if (wr_adc)
      begin
         adc_control_next = wdat;
      end
      if (ev_raw[SRC_ADC] | adc_halt)
      begin
         adc_control_next[BIT_ADC_RUN] = 1'b0; // [RULE_02] [RULE_03]
      end
   end

   // read mux
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      case (avs_address_i)
         OFS_FLAG: rdata_next[7:0] = irq_flag_reg;
         OFS_IEN:  rdata_next[7:0] = irq_enable_reg;
         OFS_WAKE: rdata_next[7:0] = wake_control_reg;
         OFS_ADC:  rdata_next[7:0] = adc_control_reg;
         OFS_LVD:  rdata_next[7:0] = low_voltage_control_reg;
         OFS_STAT: rdata_next[7:0] = {service_reg[7:1], gie_reg};
         OFS_WDOG: rdata_next[7:0] = watchdog_reg;
         default:  rdata_next = 32'h0000_0000; // unmapped reads zero
      endcase
   end

   // pin synchroniser and edge history
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pin_s1_reg <= 1'b1;
         pin_s2_reg <= 1'b1;
         pin_s3_reg <= 1'b1;
      end
      else
      begin
         pin_s1_reg <= ext_pin_i;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   // bus answer, one wait cycle per access
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         done_reg  <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         done_reg  <= bus_take;
         rdata_reg <= rdata_next;
      end
   end

   // software-written control registers
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_enable_reg          <= RST_REG8;
         wake_control_reg        <= RST_REG8;
         low_voltage_control_reg <= RST_REG8;
         watchdog_reg            <= RST_WDOG;
      end
      else
      begin
         if (wr_ien)
         begin
            irq_enable_reg <= wdat;
         end
         if (wr_wake)
         begin
            wake_control_reg <= wdat;
         end
         if (wr_lvd)
         begin
            low_voltage_control_reg <= wdat;
         end
         if (wr_wdog)
         begin
            watchdog_reg <= wdat;
         end
      end
   end

   // hardware-updated state
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_flag_reg    <= RST_REG8;
         adc_control_reg <= RST_REG8;
         service_reg     <= RST_REG8;
         state_reg       <= ST_IDLE;
         sel_reg         <= 3'h0;
      end
      else
      begin
         irq_flag_reg    <= irq_flag_next;
         adc_control_reg <= adc_control_next;
         service_reg     <= service_next;
         state_reg       <= state_next;
         if (state_reg == ST_IDLE)
         begin
            sel_reg <= sel_next; // frozen while offered
         end
      end
   end

   // global enable, set and cleared by core instructions
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         gie_reg <= 1'b0;
      end
      else if (global_irq_on_instr_i)
      begin
         gie_reg <= 1'b1;
      end
      else if (global_irq_off_instr_i)
      begin
         gie_reg <= 1'b0;
      end
   end

   // wake and watchdog pulses
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wake_reg   <= 1'b0;
         rstreq_reg <= 1'b0;
      end
      else
      begin
         wake_reg   <= (|ev_wake) | (sleep_i & watchdog_timeout_i & wdog_en); // [RULE_04]
         rstreq_reg <= watchdog_timeout_i & wdog_en; // [RULE_20]
      end
   end

   // outputs
   assign avs_waitrequest_o    = bus_req & ~done_reg;
   assign avs_readdata_o       = rdata_reg;
   assign vector_req_o.valid   = (state_reg == ST_VEC);
   assign vector_req_o.vector  = VEC_TAB[sel_reg];
   assign wake_o               = wake_reg;
   assign reset_req_o          = rstreq_reg;
   assign reset_vector_o       = VEC_RESET; // [RULE_20]
   assign osc_keep_running_o   = sleep_i & adc_wake & adc_run; // [RULE_04]
   assign adc_stop_o           = sleep_i & ~adc_wake; // [RULE_02] [RULE_15]
   assign conversion_running_o = adc_run;

endmodule
`default_nettype wire

// ===== rtl/swd_pkg.sv
package swd_pkg;

   // source index, equal to its bit in the flag register and, except for LVD, in the enable register
   localparam int SRC_N   = 8;
   localparam int SRC_TMR = 0;
   localparam int SRC_PW3 = 1;
   localparam int SRC_EXT = 2;
   localparam int SRC_ADC = 3;
   localparam int SRC_PW1 = 4;
   localparam int SRC_PW2 = 5;
   localparam int SRC_LVD = 6;
   localparam int SRC_CMP = 7;

   // register byte offsets
   localparam logic [4:0] OFS_FLAG  = 5'h00;
   localparam logic [4:0] OFS_IEN   = 5'h04;
   localparam logic [4:0] OFS_WAKE  = 5'h08;
   localparam logic [4:0] OFS_ADC   = 5'h0C;
   localparam logic [4:0] OFS_LVD   = 5'h10;
   localparam logic [4:0] OFS_STAT  = 5'h14;
   localparam logic [4:0] OFS_WDOG  = 5'h18;

   // field positions
   localparam int BIT_WAKE_CMP = 2;
   localparam int BIT_WAKE_ADC = 3;
   localparam int BIT_ADC_RUN  = 0;
   localparam int BIT_LVD_WAKE = 3;
   localparam int BIT_LVD_IEN  = 4;
   localparam int BIT_WDOG_EN  = 7;

   // reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [7:0] RST_WDOG = 8'h00;

   // vector addresses, indexed by source
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [7:0] VEC_TAB [SRC_N] = '{
      8'h09, 8'h18, 8'h03, 8'h0C, 8'h12, 8'h15, 8'h1B, 8'h12};

   // peripheral event pulses, one bit per source in index order
   typedef struct packed {
      logic cmp;
      logic lvd;
      logic pwm2;
      logic pwm1;
      logic adc;
      logic ext;
      logic pwm3;
      logic tmr;
   } swd_evt_t;

   // vector request towards the core sequencer
   typedef struct packed {
      logic       valid;
      logic [7:0] vector;
   } swd_vec_t;

   // dispatch states, gray along idle -> vector -> release
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_VEC  = 2'b01,
      ST_REL  = 2'b11
   } swd_state_t;

endpackage

// ===== verif/swd_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// core sequencer: takes each vector lat_i + 1 cycles after it is first offered
module swd_core_model
   import swd_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic [3:0]        lat_i,
   input  wire swd_pkg::swd_vec_t vector_req_i,
   output logic                   vector_ack_o
);
   logic [3:0] wait_reg;    // cycles spent on the current vector
   wire        busy = vector_req_i.valid && !vector_ack_o;
   // one ack pulse per vector, never two in a row
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wait_reg <= 4'h0;
         vector_ack_o <= 1'b0;
      end
      else
      begin
         vector_ack_o <= busy && (wait_reg == lat_i);
         wait_reg <= (busy && wait_reg != lat_i) ? wait_reg + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// ===== verif/swd_dispatch_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module swd_dispatch_asserts
   import swd_pkg::*;
(
   input wire logic              clock_i,
   input wire logic              rst_i,
   input wire swd_pkg::swd_evt_t event_i,
   input wire logic              watchdog_timeout_i,
   input wire logic              sleep_i,
   input wire logic              vector_ack_i,
   input wire swd_pkg::swd_vec_t vector_req_o,
   input wire logic              wake_o,
   input wire logic              reset_req_o,
   input wire logic [7:0]        reset_vector_o,
   input wire logic              osc_keep_running_o,
   input wire logic              adc_stop_o,
   input wire logic              conversion_running_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   wire vld = vector_req_o.valid;
   reset_vec_a: assert property (reset_req_o |-> reset_vector_o == 8'h00 && (!$past(sleep_i) || wake_o))
      else $error("reset vector not zero");
   wdog_cause_a: assert property (reset_req_o |-> $past(watchdog_timeout_i))
      else $error("reset request without time-out");
   vec_hold_a: assert property (vld && !vector_ack_i |=> vld && $stable(vector_req_o.vector))
      else $error("vector changed before ack");
   ack_drop_a: assert property (vld && vector_ack_i |=> !vld)
      else $error("vector held after ack");
   vec_table_a: assert property (vld |-> vector_req_o.vector inside
      {8'h09, 8'h12, 8'h03, 8'h0C, 8'h15, 8'h1B, 8'h18})
      else $error("vector outside table");
   wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
      else $error("wake while awake");
   wake_cause_a: assert property (wake_o |-> $past(event_i.cmp) || $past(event_i.adc)
      || $past(event_i.lvd) || $past(watchdog_timeout_i))
      else $error("wake without event");
   adc_abort_a: assert property (sleep_i && adc_stop_o |=> !conversion_running_o)
      else $error("conversion kept in sleep");
   osc_excl_a: assert property (osc_keep_running_o |-> !adc_stop_o)
      else $error("converter stopped while clock kept");
   cover property (vld && vector_ack_i);
   cover property (wake_o);
   cover property (reset_req_o && wake_o);
endmodule
bind swd_dispatch swd_dispatch_asserts swd_dispatch_asserts_inst (.clock_i, .rst_i,
   .event_i, .watchdog_timeout_i, .sleep_i, .vector_ack_i, .vector_req_o, .wake_o,
   .reset_req_o, .reset_vector_o, .osc_keep_running_o, .adc_stop_o, .conversion_running_o);
`default_nettype wire

// ===== verif/swd_dispatch_tb.sv
`timescale 1ns/10ps
`default_nettype none
module swd_dispatch_tb;
   import swd_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [4:0]  adr = 5'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  be = 4'hF;
   logic [31:0] rdat;
   logic        wreq;
   swd_evt_t    evt = '0;
   logic        pin = 1'b1;
   logic        wdt = 1'b0;
   logic        slp = 1'b0;
   logic        gon = 1'b0;
   logic        goff = 1'b0;
   logic        ack;
   swd_vec_t    vreq;
   logic        wake, rreq, osc, astop, crun;
   logic [7:0]  rvec;
   logic [7:0]  q;
   logic [3:0]  lat = 4'h0;
   logic [7:0]  taken[$];
   int          n_fail = 0;
   int          num_checks = 0;
   int          n_wake = 0;
   int          n_rst = 0;
   always #2.5 clock_i = ~clock_i;
   swd_dispatch swd_dispatch_inst (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .event_i(evt), .ext_pin_i(pin),
      .watchdog_timeout_i(wdt), .sleep_i(slp), .global_irq_on_instr_i(gon),
      .global_irq_off_instr_i(goff), .vector_ack_i(ack), .vector_req_o(vreq), .wake_o(wake),
      .reset_req_o(rreq), .reset_vector_o(rvec), .osc_keep_running_o(osc),
      .adc_stop_o(astop), .conversion_running_o(crun));
   swd_core_model swd_core_model_inst (.clock_i(clock_i), .rst_i(rst_i), .lat_i(lat),
      .vector_req_i(vreq), .vector_ack_o(ack));
   // pulse counters and log of vectors taken
   always @(negedge clock_i)
   begin
      n_wake += (wake === 1'b1);
      n_rst += (rreq === 1'b1);
      if (vreq.valid === 1'b1 && ack === 1'b1)
         taken.push_back(vreq.vector);
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon access, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clock_i);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do
         @(posedge clock_i);
      while (wreq !== 1'b0);
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic stim(input swd_evt_t e, input logic w, input logic on, input logic off);
      @(posedge clock_i);
      evt <= e;
      wdt <= w;
      gon <= on;
      goff <= off;
      @(posedge clock_i);
      evt <= '0;
      wdt <= 1'b0;
      gon <= 1'b0;
      goff <= 1'b0;
      repeat (6) @(posedge clock_i);
   endtask
   task automatic sleep(input logic v);
      @(posedge clock_i);
      slp <= v;
      repeat (3) @(negedge clock_i);
   endtask
   // next vector taken by the core, bounded wait
   task automatic vchk(input logic [7:0] v);
      for (int i = 0; i < 60 && taken.size() == 0; i++)
         @(negedge clock_i);
      chk(taken.size() > 0 ? taken.pop_front() : 8'hEE, v);
   endtask
   task automatic t_reset;
      for (int a = 0; a < 32; a += 4)
      begin
         bus(1'b0, 5'(a), 8'h00);
         chk(q, 8'h00);
      end
      be <= 4'h0;
      bus(1'b1, OFS_IEN, 8'hFF);
      be <= 4'hF;
      bus(1'b0, OFS_IEN, 8'h00);
      chk(q, 8'h00);
   endtask
   task automatic t_ext;
      bus(1'b1, OFS_IEN, 8'h04);
      stim('0, 1'b0, 1'b1, 1'b0);
      @(posedge clock_i);
      pin <= 1'b0;
      repeat (8) @(posedge clock_i);
      pin <= 1'b1;
      vchk(8'h03);
      bus(1'b0, OFS_FLAG, 8'h00);
      chk(q, 8'h04);
      bus(1'b1, OFS_FLAG, 8'h04);
      bus(1'b0, OFS_FLAG, 8'h00);
      chk(q, 8'h00);
   endtask
   task automatic t_pwm;
      bus(1'b1, OFS_IEN, 8'h32);
      stim(swd_evt_t'(8'h10), 1'b0, 1'b0, 1'b0);
      vchk(8'h12);
      stim(swd_evt_t'(8'h20), 1'b0, 1'b0, 1'b0);
      vchk(8'h15);
      stim(swd_evt_t'(8'h02), 1'b0, 1'b0, 1'b0);
      vchk(8'h18);
      bus(1'b1, OFS_FLAG, 8'hFF);
      stim('0, 1'b0, 1'b0, 1'b1);
      stim(swd_evt_t'(8'h20), 1'b0, 1'b0, 1'b0);
      chk(taken.size(), 0);
      bus(1'b0, OFS_FLAG, 8'h00);
      chk(q, 8'h20);
      bus(1'b1, OFS_FLAG, 8'hFF);
      bus(1'b1, OFS_IEN, 8'h00);
   endtask
   task automatic t_adc;
      bus(1'b1, OFS_ADC, 8'h01);
      sleep(1'b1);
      chk({astop, osc, crun}, 3'b100);
      sleep(1'b0);
      bus(1'b1, OFS_IEN, 8'h08);
      bus(1'b1, OFS_ADC, 8'h01);
      sleep(1'b1);
      bus(1'b0, OFS_FLAG, 8'h00);
      chk({q[3], crun, astop}, 3'b101);
      sleep(1'b0);
      bus(1'b1, OFS_FLAG, 8'hFF);
      bus(1'b1, OFS_IEN, 8'h00);
      bus(1'b1, OFS_WAKE, 8'h08);
      bus(1'b1, OFS_ADC, 8'h01);
      sleep(1'b1);
      chk({astop, osc, crun}, 3'b011);
      stim(swd_evt_t'(8'h08), 1'b0, 1'b0, 1'b0);
      chk({n_wake[7:0], crun}, 9'h002);
      n_wake = 0;
      sleep(1'b0);
      bus(1'b1, OFS_WAKE, 8'h00);
   endtask
   // all wake/irq enable pairs in sleep, then the vectored case
   task automatic combo(input swd_evt_t e, input logic [4:0] wa, input logic [7:0] wv,
                        input logic [4:0] ia, input logic [7:0] iv, input int fb,
                        input logic [7:0] v);
      for (int k = 0; k < 4; k++)
      begin
         stim('0, 1'b0, 1'b0, 1'b1);
         bus(1'b1, wa, k[1] ? wv : 8'h00);
         bus(1'b1, ia, ((k[1] && wa == ia) ? wv : 8'h00) | (k[0] ? iv : 8'h00));
         sleep(1'b1);
         n_wake = 0;
         stim(e, 1'b0, 1'b0, 1'b0);
         chk(n_wake, k[1]);
         bus(1'b0, OFS_FLAG, 8'h00);
         chk({q[fb], 8'(taken.size())}, {k[0], 8'h00});
         bus(1'b1, OFS_FLAG, 8'hFF);
         sleep(1'b0);
      end
      stim('0, 1'b0, 1'b1, 1'b0);
      sleep(1'b1);
      n_wake = 0;
      stim(e, 1'b0, 1'b0, 1'b0);
      chk(n_wake, 1);
      vchk(v);
      sleep(1'b0);
      bus(1'b1, wa, 8'h00);
      bus(1'b1, ia, 8'h00);
      bus(1'b1, OFS_FLAG, 8'hFF);
      stim(e, 1'b0, 1'b0, 1'b0);
      bus(1'b0, OFS_FLAG, 8'h00);
      chk({q, 8'(taken.size())}, 16'h0000);
   endtask
   task automatic t_wdog;
      n_rst = 0;
      n_wake = 0;
      stim('0, 1'b1, 1'b0, 1'b0);
      chk(n_rst, 0);
      bus(1'b1, OFS_WDOG, 8'h80);
      stim('0, 1'b1, 1'b0, 1'b0);
      sleep(1'b1);
      stim('0, 1'b1, 1'b0, 1'b0);
      chk({n_rst[3:0], n_wake[3:0], rvec}, 16'h2100);
      sleep(1'b0);
   endtask
   task automatic t_prio;
      lat <= 4'hA;
      bus(1'b1, OFS_IEN, 8'h83);
      stim(swd_evt_t'(8'h83), 1'b0, 1'b0, 1'b0);
      vchk(8'h09);
      vchk(8'h18);
      vchk(8'h12);
      bus(1'b0, OFS_FLAG, 8'h00);
      chk(q, 8'h83);
      bus(1'b0, OFS_STAT, 8'h00);
      chk(q, 8'h01);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset;
      t_ext;
      t_pwm;
      t_adc;
      combo(swd_evt_t'(8'h80), OFS_WAKE, 8'h04, OFS_IEN, 8'h80, 7, 8'h12);
      combo(swd_evt_t'(8'h40), OFS_LVD, 8'h08, OFS_LVD, 8'h10, 6, 8'h1B);
      combo(swd_evt_t'(8'h08), OFS_WAKE, 8'h08, OFS_IEN, 8'h08, 3, 8'h0C);
      t_wdog;
      t_prio;
      tally_and_finish;
   end
   // hang guard
   initial
   begin
      repeat (30000) @(posedge clock_i);
      n_fail++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
